// ### tds_pkg.sv
// Shared constants for the time-of-day counter with sync
package tds_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_NS          = 50;                  // pclk period, 20 MHz
    localparam int REF_PERIOD_NS   = 1000;                // 1 MHz reference
    localparam int INT_DIV_CYC     = REF_PERIOD_NS / CLK_NS;
    localparam int TICK_W_NS       = 20000;               // Second/ten-second pulse width
    localparam int TICK_W_CYC      = TICK_W_NS / CLK_NS;
    localparam int EVT_W_NS        = 10000;               // Event pulse width
    localparam int EVT_W_CYC       = EVT_W_NS / CLK_NS;
    localparam int REF_LOSS_NS     = 2000;                // No edge this long: reference gone
    localparam int REF_LOSS_CYC    = REF_LOSS_NS / CLK_NS;
    localparam int REF_GOOD_EDGES  = 4;                   // Counted edges to return to external; the first edge after a loss is not counted

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_MASK     = 8'h08;
    localparam logic [7:0] OFF_PRE_TIME = 8'h0C;
    localparam logic [7:0] OFF_PRE_SUB  = 8'h10;
    localparam logic [7:0] OFF_PRE_DAY  = 8'h14;
    localparam logic [7:0] OFF_TIME     = 8'h18;
    localparam logic [7:0] OFF_DAY      = 8'h1C;
    localparam logic [7:0] OFF_SUB      = 8'h20;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int CTRL_ARM      = 0;
    localparam int CTRL_SUBSEC   = 1;
    localparam int CTRL_SYNC_INT = 2;
    localparam int CTRL_EVT_EN   = 3;
    localparam int CTRL_RATE_A   = 4;                     // Bits 6:4
    localparam int CTRL_RATE_B   = 7;                     // Bits 9:7
    localparam int CTRL_REF_INT  = 10;                    // Read only

    // Event rate codes
    localparam logic [2:0] RATE_SEC  = 3'h0;
    localparam logic [2:0] RATE_TEN  = 3'h1;
    localparam logic [2:0] RATE_MIN  = 3'h2;
    localparam logic [2:0] RATE_HOUR = 3'h3;
    localparam logic [2:0] RATE_DAY  = 3'h4;
    localparam logic [2:0] RATE_A_RST = RATE_DAY;
    localparam logic [2:0] RATE_B_RST = RATE_SEC;

    // Status bits
    localparam int ST_SEC     = 0;
    localparam int ST_LOAD    = 1;
    localparam int ST_REF_LOST = 2;
    localparam int ST_REF_BACK = 3;
    localparam int ST_EVT_A   = 4;
    localparam int ST_EVT_B   = 5;
    localparam int ST_W       = 6;

    // Day-of-year limits (BCD)
    localparam logic [11:0] DAY_FIRST = 12'h001;
    localparam logic [11:0] DAY_LAST  = 12'h366;

    // Reference selection states
    typedef enum logic [1:0] {
        REF_EXT = 2'b01,
        REF_INT = 2'b10
    } tds_ref_e;

endpackage

// ### tds_pulse.sv
// Fixed-width pulse stretcher for tick and event outputs
`timescale 1ns/1ps
`default_nettype none

module tds_pulse #(
    parameter int WIDTH_CYC = 400
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire,
    output logic      pulse
);
    typedef struct packed {
        logic        active;
        logic [15:0] cnt;
    } tds_pulse_s;

    tds_pulse_s st_reg;
    tds_pulse_s st_next;

    // Restart on every fire; a new fire extends the pulse
    always_comb
    begin
        st_next = st_reg;
        if (fire)
        begin
            st_next.active = 1'b1;
            st_next.cnt    = 16'(WIDTH_CYC - 1);
        end
        else if (st_reg.cnt != 16'h0000)
            st_next.cnt = st_reg.cnt - 16'h0001;
        else
            st_next.active = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign pulse = st_reg.active;
endmodule

`default_nettype wire

// ### tds_top.sv
// Time-of-day counter with reference fallback, sync load and event outputs
//
// Overview of operation
// - Divide the 1 MHz reference to a second tick; advance day and time from it.
// - Use internal 1 MHz when external reference vanishes; return when it comes back.
// - Ten-second tick output is a pulse about 20 us wide.
// - Each event output picks its rate: second, ten seconds, minute, hour, day.
// - Every event pulse is 10 us wide.
// - After reset event A runs daily and event B per second.
// - Daily rate fires when time to the microsecond equals preset; needs event enable.
// - Per-second event is delayed by the subsecond preset; zero means with tick.
// - Hours, minutes and seconds always shown as 20 BCD lines.
// - Code lines: tens hours 2, hours 4, tens min 3, min 4, tens sec 3, sec 4.
// - Armed full-set: next sync edge loads day and time and aligns the tick.
// - Internal sync source uses the next ten-second tick as the event.
// - Subsecond-only mode realigns the divider and leaves day and time alone.
// - After one armed load, further sync edges are ignored until rearmed.
// - On the sync event every divider decade loads its preset digit at once.
`timescale 1ns/1ps
`default_nettype none

module tds_top
    import tds_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_ref,
    input  wire logic        sync_in,
    output logic             second_tick,
    output logic             ten_second_tick,
    output logic             event_output_a,
    output logic             event_output_b,
    output logic [19:0]      time_code,
    output logic             ref_internal,
    output logic             sync_armed,
    output logic             irq
);
    typedef struct packed {
        tds_ref_e         ref_st;
        logic             ref_prev;
        logic [6:0]       gap;
        logic [2:0]       good;
        logic [4:0]       div;
        logic             sync_prev;
        logic             armed;
        logic             subsec_only;
        logic             sync_int;
        logic             event_en;
        logic [2:0]       rate_a;
        logic [2:0]       rate_b;
        logic [19:0]      pre_time;
        logic [23:0]      pre_sub;
        logic [11:0]      pre_day;
        logic [5:0][3:0]  sub;
        logic [19:0]      tod;        // Packed as the time code lines
        logic [11:0]      day;
        logic [ST_W-1:0]  status;
        logic [ST_W-1:0]  mask;
        logic             irq;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } tds_s;

    tds_s st_reg;
    tds_s st_next;

    logic us_tick, ref_edge, sync_rise, trigger, sec_roll, sec_strobe;
    logic ten_strobe, min_strobe, hr_strobe, day_strobe;
    logic sec_evt, day_evt, fire_a, fire_b;
    logic setup, access, wr;
    logic [3:0] fires;

    // Rate selector for the event outputs
    function automatic logic rate_pick(input logic [2:0] rate, input logic s, input logic t,
                                       input logic m, input logic h, input logic d);
        logic r;
        r = 1'b0;
        case (rate)
            RATE_SEC:  r = s;
            RATE_TEN:  r = t;
            RATE_MIN:  r = m;
            RATE_HOUR: r = h;
            RATE_DAY:  r = d;
            default:   r = 1'b0;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic       carry;
        logic [3:0] d0;
        st_next = st_reg;
        carry   = 1'b0;
        d0      = 4'h0;
        us_tick = 1'b0;                  // Illegal reference state gives no tick

        // Reference watch: edges of ext_ref, gap counter, fallback divider
        ref_edge         = ext_ref & ~st_reg.ref_prev;
        st_next.ref_prev = ext_ref;
        st_next.div      = (st_reg.div == 5'(INT_DIV_CYC - 1)) ? 5'h00 : st_reg.div + 5'h01;
        if (ref_edge)
            st_next.gap = 7'h00;
        else if (st_reg.gap != 7'(REF_LOSS_CYC))
            st_next.gap = st_reg.gap + 7'h01;
        unique case (st_reg.ref_st)
            REF_EXT:
            begin
                us_tick = ref_edge;
                if (st_reg.gap == 7'(REF_LOSS_CYC))
                begin
                    st_next.ref_st = REF_INT;
                    st_next.good   = 3'h0;
                    st_next.div    = 5'h00;
                end
            end
            REF_INT:
            begin
                us_tick = (st_reg.div == 5'(INT_DIV_CYC - 1));
                if (st_reg.gap == 7'(REF_LOSS_CYC))
                    st_next.good = 3'h0;
                else if (ref_edge)
                    st_next.good = st_reg.good + 3'h1;
                if (ref_edge && st_reg.good == 3'(REF_GOOD_EDGES - 1))
                    st_next.ref_st = REF_EXT;
            end
        endcase

        // Subsecond decades, microseconds upward
        carry = us_tick;
        for (int i = 0; i < 6; i++)
        begin
            if (carry)
            begin
                st_next.sub[i] = (st_reg.sub[i] == 4'h9) ? 4'h0 : st_reg.sub[i] + 4'h1;
                carry          = (st_reg.sub[i] == 4'h9);
            end
        end
        sec_roll = carry;

        // Seconds, minutes, hours, day (tod = hrT,hrU,mnT,mnU,scT,scU)
        ten_strobe = sec_roll && st_reg.tod[3:0] == 4'h9;
        min_strobe = ten_strobe && st_reg.tod[6:4] == 3'h5;
        hr_strobe  = min_strobe && st_reg.tod[10:7] == 4'h9 && st_reg.tod[13:11] == 3'h5;
        day_strobe = hr_strobe && st_reg.tod[19:18] == 2'h2 && st_reg.tod[17:14] == 4'h3;
        if (sec_roll)
            st_next.tod[3:0] = ten_strobe ? 4'h0 : st_reg.tod[3:0] + 4'h1;
        if (ten_strobe)
            st_next.tod[6:4] = min_strobe ? 3'h0 : st_reg.tod[6:4] + 3'h1;
        if (min_strobe)
            st_next.tod[10:7] = (st_reg.tod[10:7] == 4'h9) ? 4'h0 : st_reg.tod[10:7] + 4'h1;
        if (min_strobe && st_reg.tod[10:7] == 4'h9)
            st_next.tod[13:11] = hr_strobe ? 3'h0 : st_reg.tod[13:11] + 3'h1;
        if (day_strobe)
            st_next.tod[19:14] = 6'h00;
        else if (hr_strobe && st_reg.tod[17:14] == 4'h9)
        begin
            st_next.tod[17:14] = 4'h0;
            st_next.tod[19:18] = st_reg.tod[19:18] + 2'h1;
        end
        else if (hr_strobe)
            st_next.tod[17:14] = st_reg.tod[17:14] + 4'h1;
        if (day_strobe)
        begin
            if (st_reg.day == DAY_LAST)
                st_next.day = DAY_FIRST;
            else
            begin
                carry = 1'b1;
                for (int i = 0; i < 3; i++)
                begin
                    d0 = st_reg.day[i*4 +: 4];
                    if (carry)
                    begin
                        st_next.day[i*4 +: 4] = (d0 == 4'h9) ? 4'h0 : d0 + 4'h1;
                        carry                 = (d0 == 4'h9);
                    end
                end
            end
        end

        // Armed sync: one load, then ignore edges until rearmed
        sync_rise         = sync_in & ~st_reg.sync_prev;
        st_next.sync_prev = sync_in;
        trigger = st_reg.armed && (st_reg.sync_int ? ten_strobe : sync_rise);
        if (trigger)
        begin
            st_next.sub   = st_reg.pre_sub;
            st_next.div   = 5'h00;
            st_next.armed = 1'b0;
            if (!st_reg.subsec_only)
            begin
                st_next.tod = st_reg.pre_time;
                st_next.day = st_reg.pre_day;
            end
        end
        // Zero subsecond preset puts the tick on the sync edge itself
        sec_strobe = trigger ? (st_reg.pre_sub == 24'h00_0000) : sec_roll;

        // Event strobes, evaluated on the value the counters take next
        sec_evt = (us_tick || trigger) && st_next.sub == st_reg.pre_sub;
        day_evt = sec_evt && st_next.tod == st_reg.pre_time;
        fire_a  = st_reg.event_en && rate_pick(st_reg.rate_a, sec_evt, ten_strobe,
                                               min_strobe, hr_strobe, day_evt);
        fire_b  = st_reg.event_en && rate_pick(st_reg.rate_b, sec_evt, ten_strobe,
                                               min_strobe, hr_strobe, day_evt);

        // APB slave: answer one cycle after setup, no wait beyond that
        setup   = psel && !penable;
        access  = psel && penable && st_reg.pready;
        wr      = access && pwrite;
        st_next.pready  = setup;
        st_next.pslverr = 1'b0;
        if (setup)
        begin
            st_next.prdata = 32'h0000_0000;
            case (paddr)
                OFF_CTRL:     st_next.prdata[10:0] = {st_reg.ref_st == REF_INT,
                                  st_reg.rate_b, st_reg.rate_a, st_reg.event_en,
                                  st_reg.sync_int, st_reg.subsec_only, st_reg.armed};
                OFF_STATUS:   st_next.prdata[ST_W-1:0] = st_reg.status;
                OFF_MASK:     st_next.prdata[ST_W-1:0] = st_reg.mask;
                OFF_PRE_TIME: st_next.prdata[19:0] = st_reg.pre_time;
                OFF_PRE_SUB:  st_next.prdata[23:0] = st_reg.pre_sub;
                OFF_PRE_DAY:  st_next.prdata[11:0] = st_reg.pre_day;
                OFF_TIME:     st_next.prdata[19:0] = st_reg.tod;
                OFF_DAY:      st_next.prdata[11:0] = st_reg.day;
                OFF_SUB:      st_next.prdata[23:0] = st_reg.sub;
                default:      st_next.pslverr = 1'b1;
            endcase
        end
        if (wr)
        begin
            case (paddr)
                OFF_CTRL:
                begin
                    if (pwdata[CTRL_ARM])
                        st_next.armed = 1'b1;      // Rearm beats a same-cycle load
                    st_next.subsec_only = pwdata[CTRL_SUBSEC];
                    st_next.sync_int    = pwdata[CTRL_SYNC_INT];
                    st_next.event_en    = pwdata[CTRL_EVT_EN];
                    st_next.rate_a      = pwdata[CTRL_RATE_A +: 3];
                    st_next.rate_b      = pwdata[CTRL_RATE_B +: 3];
                end
                OFF_MASK:     st_next.mask     = pwdata[ST_W-1:0];
                OFF_PRE_TIME: st_next.pre_time = pwdata[19:0];
                OFF_PRE_SUB:  st_next.pre_sub  = pwdata[23:0];
                OFF_PRE_DAY:  st_next.pre_day  = pwdata[11:0];
                default:      ;
            endcase
        end

        // Sticky status: write one clears, a new event in the same cycle wins
        if (wr && paddr == OFF_STATUS)
            st_next.status = st_reg.status & ~pwdata[ST_W-1:0];
        st_next.status = st_next.status | {fire_b, fire_a,
            st_reg.ref_st == REF_INT && st_next.ref_st == REF_EXT,
            st_reg.ref_st == REF_EXT && st_next.ref_st == REF_INT, trigger, sec_strobe};
        st_next.irq = |(st_next.status & st_next.mask);
        fires = {fire_b, fire_a, ten_strobe && !trigger, sec_strobe};
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg        <= '0;
            st_reg.ref_st <= REF_EXT;
            st_reg.rate_a <= RATE_A_RST;
            st_reg.rate_b <= RATE_B_RST;
            st_reg.day    <= DAY_FIRST;
        end
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Pulse outputs: ticks 20 us, events 10 us
    // ------------------------------------------------------------------
    localparam int PW [4] = '{TICK_W_CYC, TICK_W_CYC, EVT_W_CYC, EVT_W_CYC};
    logic [3:0] pulses;
    for (genvar g = 0; g < 4; g++)
    begin : g_pulse
        tds_pulse #(.WIDTH_CYC(PW[g])) u_pulse (
            .pclk    (pclk),
            .presetn (presetn),
            .fire    (fires[g]),
            .pulse   (pulses[g])
        );
    end

    assign second_tick     = pulses[0];
    assign ten_second_tick = pulses[1];
    assign event_output_a  = pulses[2];
    assign event_output_b  = pulses[3];
    assign time_code       = st_reg.tod;
    assign ref_internal    = (st_reg.ref_st == REF_INT);
    assign sync_armed      = st_reg.armed;
    assign irq             = st_reg.irq;
    assign prdata          = st_reg.prdata;
    assign pready          = st_reg.pready;
    assign pslverr         = st_reg.pslverr;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_code_digits;
        time_code[19:18] <= 2'h2 && time_code[13:11] <= 3'h5 && time_code[6:4] <= 3'h5;
    endproperty
    a_code_digits: assert property (p_code_digits) else $error("bad BCD digit");
    property p_hour_range;
        !(time_code[19:18] == 2'h2 && time_code[17:14] > 4'h3);
    endproperty
    a_hour_range: assert property (p_hour_range) else $error("hour above 23");
    property p_code_moves;
        !$stable(time_code) |-> $past(sec_roll || trigger);
    endproperty
    a_code_moves: assert property (p_code_moves) else $error("code changed off tick");
    property p_tick_width;
        $rose(second_tick) |-> second_tick [*8];
    endproperty
    a_tick_width: assert property (p_tick_width) else $error("second tick short");
    property p_evt_width;
        $rose(event_output_b) |-> event_output_b [*8];
    endproperty
    a_evt_width: assert property (p_evt_width) else $error("event pulse short");
    property p_load_needs_arm;
        trigger |-> sync_armed ##1 !sync_armed || $past(wr);
    endproperty
    a_load_needs_arm: assert property (p_load_needs_arm) else $error("load while idle");
    property p_full_load;
        trigger && !st_reg.subsec_only |=> time_code == $past(st_reg.pre_time);
    endproperty
    a_full_load: assert property (p_full_load) else $error("time not loaded");
    property p_sub_only;
        trigger && st_reg.subsec_only |=> time_code == $past(time_code);
    endproperty
    a_sub_only: assert property (p_sub_only) else $error("time moved in subsec mode");
    property p_int_sync;
        sync_armed && st_reg.sync_int && ten_strobe && !st_reg.subsec_only
            |=> time_code == $past(st_reg.pre_time);
    endproperty
    a_int_sync: assert property (p_int_sync) else $error("internal sync missed");
    property p_ref_loss;
        st_reg.ref_st == REF_EXT && st_reg.gap == 7'(REF_LOSS_CYC) |=> ##1 ref_internal;
    endproperty
    a_ref_loss: assert property (p_ref_loss) else $error("no fallback");
    property p_sec_evt;
        st_reg.event_en && st_reg.rate_b == RATE_SEC && sec_evt |-> ##[1:2] $rose(event_output_b);
    endproperty
    a_sec_evt: assert property (p_sec_evt) else $error("second event missing");

    c_load:   cover property (trigger);
    c_refint: cover property ($rose(ref_internal));
    c_evt_a:  cover property ($rose(event_output_a));
    c_day:    cover property (day_strobe);
endmodule

`default_nettype wire

// ### tds_far_model.sv
// Model of the reference source and the sync source facing the counter
`timescale 1ns/1ps
`default_nettype none
module tds_far_model
    import tds_pkg::*;
(
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic sync_req,
    output logic      ext_ref,
    output logic      sync_in
);
    int unsigned div_cnt = 0;
    int unsigned sync_cnt = 0;
    logic        req_d = 1'b0;
    // ----
    // Square wave and sync pulse
    // ----
    // A pulled reference stands low, like a removed cable
    initial ext_ref = 1'b0;
    initial sync_in = 1'b0;
    always @(posedge pclk)
    begin
        div_cnt <= (div_cnt == INT_DIV_CYC - 1) ? 0 : div_cnt + 1;
        ext_ref <= run && (div_cnt < INT_DIV_CYC / 2);
        req_d <= sync_req;
        // Three cycles high, past the minimum width
        if (sync_req != req_d) sync_cnt <= 3;
        else if (sync_cnt != 0) sync_cnt <= sync_cnt - 1;
        sync_in <= (sync_cnt != 0);
    end
endmodule
`default_nettype wire

// ### tds_top_bench.sv
// Self-checking bench for the time-of-day counter with sync
`timescale 1ns/1ps
`default_nettype none
module tds_top_bench
    import tds_pkg::*;
;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = ZERO, prdata, rd;
    logic        pready, pslverr, err, ext_ref, sync_in, run = 1'b1, sync_req = 1'b0;
    logic        second_tick, ten_second_tick, event_output_a, event_output_b;
    logic        ref_internal, sync_armed, irq;
    logic [19:0] time_code;
    int          fail_count = 0, num_checks = 0, cyc = 0;
    tds_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_ref, .sync_in, .second_tick, .ten_second_tick,
        .event_output_a, .event_output_b, .time_code, .ref_internal, .sync_armed, .irq);
    tds_far_model far (.pclk, .run, .sync_req, .ext_ref, .sync_in);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? second_tick : event_output_b;
    endfunction
    task automatic rise(input int s);
        while (pick(s) !== 1'b1) @(posedge pclk);
    endtask
    task automatic width(input int s, input int w, input string what);
        int n;
        n = 0;
        while (pick(s) === 1'b1)
        begin
            n++;
            @(posedge pclk);
        end
        chk(what, 32'(w), 32'(n));
    endtask
    task automatic sync_pulse;
        sync_req <= ~sync_req;
        @(posedge pclk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        apb(1'b0, OFF_CTRL, ZERO);
        chk("ctrl after reset", 32'h0000_0040, rd);
        chk("time after reset", ZERO, 32'(time_code));
        apb(1'b0, 8'h40, ZERO);
        chk("unmapped error", ONE, 32'(err));
        chk("unmapped data", ZERO, rd);
    endtask
    // 23:59:59 day 366, ten microseconds before the roll
    task automatic t_full_load;
        apb(1'b1, OFF_PRE_TIME, 32'h0008_ECD9);
        apb(1'b1, OFF_PRE_SUB, 32'h0099_9990);
        apb(1'b1, OFF_PRE_DAY, 32'h0000_0366);
        apb(1'b1, OFF_MASK, 32'h0000_0002);
        apb(1'b1, OFF_CTRL, 32'h0000_0049);
        @(posedge pclk);
        chk("armed", ONE, 32'(sync_armed));
        sync_pulse();
        rise(1);
        chk("daily event", ONE, 32'(event_output_a));
        chk("loaded time", 32'h0008_ECD9, 32'(time_code));
        chk("load irq", ONE, 32'(irq));
        chk("disarmed", ZERO, 32'(sync_armed));
        // Roll lands inside the event pulse, so both widths are timed at once
        fork
            width(1, EVT_W_CYC, "event width");
            begin
                rise(0);
                chk("rolled time", ZERO, 32'(time_code));
                chk("ten second tick", ONE, 32'(ten_second_tick));
                width(0, TICK_W_CYC, "tick width");
            end
        join
        apb(1'b0, OFF_DAY, ZERO);
        chk("rolled day", ONE, rd);
    endtask
    task automatic t_irq_ignore;
        apb(1'b1, OFF_STATUS, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk("irq cleared", ZERO, 32'(irq));
        apb(1'b1, OFF_MASK, ONE);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", ONE, 32'(irq));
        apb(1'b1, OFF_MASK, ZERO);
        sync_pulse();
        repeat (8) @(posedge pclk);
        chk("irq masked", ZERO, 32'(irq));
        chk("sync ignored", ZERO, 32'(time_code));
    endtask
    task automatic t_subsec;
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        sync_pulse();
        repeat (8) @(posedge pclk);
        chk("time kept", ZERO, 32'(time_code));
        repeat (230) @(posedge pclk);
        chk("realigned roll", ONE, 32'(time_code));
    endtask
    task automatic t_internal;
        apb(1'b1, OFF_PRE_TIME, 32'h0000_0009);
        apb(1'b1, OFF_CTRL, ONE);
        sync_pulse();
        repeat (8) @(posedge pclk);
        chk("loaded nine", 32'h0000_0009, 32'(time_code));
        apb(1'b1, OFF_STATUS, 32'h0000_0030);
        // Event A on the ten-second rate, B on the minute rate
        apb(1'b1, OFF_CTRL, 32'h0000_011D);
        repeat (300) @(posedge pclk);
        chk("internal load", 32'h0000_0009, 32'(time_code));
        chk("internal disarm", ZERO, 32'(sync_armed));
        apb(1'b0, OFF_STATUS, ZERO);
        chk("event rates", ONE, 32'(rd[ST_EVT_B:ST_EVT_A]));
    endtask
    task automatic t_ref;
        run <= 1'b0;
        repeat (80) @(posedge pclk);
        chk("internal ref", ONE, 32'(ref_internal));
        apb(1'b0, OFF_CTRL, ZERO);
        chk("ref bit", ONE, 32'(rd[CTRL_REF_INT]));
        run <= 1'b1;
        repeat (150) @(posedge pclk);
        chk("external ref", ZERO, 32'(ref_internal));
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----
    // Clock, reset, sequence and hang guard
    // ----
    initial forever #25 pclk = ~pclk;
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_full_load();
        t_irq_ignore();
        t_subsec();
        t_internal();
        t_ref();
        results();
    end
    // Whole run needs under two thousand cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            fail_count++;
            results();
        end
    end
endmodule
`default_nettype wire
